// ---- cies_pkg.sv ----
package cies_pkg;
	localparam int NUM_SRC   = 12;
	localparam int SRC_W     = 4;
	localparam int PC_W      = 12;
	localparam int SP_W      = 16;
	localparam int CLK_MHZ   = 100;
	localparam int RESP_CYC  = 4;
	localparam int RET_CYC   = 4;
	localparam int JMP_CYC   = 3;
	localparam int WAKE_CYC  = 4;
	localparam int CNT_W     = 4;
	localparam logic [PC_W-1:0] RESET_VEC = 12'h000;
	localparam logic [PC_W-1:0] VEC_BASE  = 12'h001;
	localparam logic [SP_W-1:0] SP_RESET  = 16'h0000;
	localparam logic [SP_W-1:0] SP_STEP   = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0] CNT_RESP = 4'h4;
	localparam logic [CNT_W-1:0] CNT_RET  = 4'h4;
	localparam logic [CNT_W-1:0] CNT_JMP  = 4'h3;
	localparam logic [CNT_W-1:0] CNT_WAKE = 4'h4;
	typedef enum logic [2:0] {CIES_RUN, CIES_WAKE, CIES_PUSH, CIES_JUMP, CIES_POP} cies_state_t;
endpackage : cies_pkg

// ---- cies_prio.sv ----
`timescale 1ns/1ns
module cies_prio (
	// requests
	input  wire logic [cies_pkg::NUM_SRC-1:0] req,
	// result
	output logic                              found,
	output logic [cies_pkg::SRC_W-1:0]        idx
);
	import cies_pkg::*;
	// lowest index means lowest vector address, so it wins
	always_comb begin
		found = 1'b0;
		idx   = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx   = SRC_W'(i);
			end
		end
	end
endmodule : cies_prio

// ---- cies_seq.sv ----
`timescale 1ns/1ns
module cies_seq (
	// clock and reset; mclk is the undivided core_clock
	input  wire logic                           mclk,
	input  wire logic                           reset_n,
	// sources
	input  wire logic [cies_pkg::NUM_SRC-1:0]   src_event,
	input  wire logic [cies_pkg::NUM_SRC-1:0]   src_level,
	input  wire logic [cies_pkg::NUM_SRC-1:0]   src_is_level,
	input  wire logic [cies_pkg::NUM_SRC-1:0]   src_enable,
	input  wire logic [cies_pkg::NUM_SRC-1:0]   flag_clear_wr,
	// pipeline
	input  wire logic                           instr_done,
	input  wire logic                           sei_exec,
	input  wire logic                           cli_exec,
	input  wire logic                           return_from_irq_instr,
	input  wire logic                           sleeping,
	input  wire logic                           startup_done,
	input  wire logic [cies_pkg::PC_W-1:0]      program_counter,
	input  wire logic [cies_pkg::SP_W-1:0]      sp_in,
	input  wire logic                           sp_load,
	input  wire logic [7:0]                     pop_data,
	// outputs
	output logic                                global_enable,
	output logic [cies_pkg::NUM_SRC-1:0]        flags,
	output logic                                core_stall,
	output logic                                pc_load,
	output logic [cies_pkg::PC_W-1:0]           pc_value,
	output logic [cies_pkg::SP_W-1:0]           stack_pointer,
	output logic                                mem_write,
	output logic                                mem_read,
	output logic [cies_pkg::SP_W-1:0]           mem_addr,
	output logic [7:0]                          mem_wdata,
	output logic                                irq_ack,
	output logic [cies_pkg::SRC_W-1:0]          irq_src,
	output logic                                status_save
);
	import cies_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [NUM_SRC-1:0] ev_s1, ev_s2, ev_d, lv_s1, lv_s2;
	logic [NUM_SRC-1:0] pending, next_flags, clr_hw;
	logic [NUM_SRC-1:0] ev_rise;
	logic               found, hold_one, take;
	logic               pop_last, push_last;
	logic [SRC_W-1:0]   win;
	logic [CNT_W-1:0]   cnt;
	logic [PC_W-1:0]    saved_pc;
	logic [7:0]         pop_hi;
	cies_state_t        state;

	// true on the last counted cycle of the given sequencer phase
	function automatic logic last_step(input cies_state_t st, input cies_state_t phase,
	                                   input logic [CNT_W-1:0] c);
		return (st == phase) && (c == CNT_ONE);
	endfunction : last_step

	assign pop_last  = last_step(state, CIES_POP, cnt);
	assign push_last = last_step(state, CIES_PUSH, cnt);

	// pins pass two flops before use
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ev_s1 <= '0;
			ev_s2 <= '0;
			ev_d  <= '0;
			lv_s1 <= '0;
			lv_s2 <= '0;
		end else begin
			ev_s1 <= src_event;
			ev_s2 <= ev_s1;
			ev_d  <= ev_s2;
			lv_s1 <= src_level;
			lv_s2 <= lv_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// only flag-type sources latch an edge; level types are read as they stand
	assign ev_rise = ev_s2 & ~ev_d & ~src_is_level;

	// flags: set wins over both clears so no event is lost
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			next_flags[i] = flags[i];
			if (flag_clear_wr[i])
				next_flags[i] = 1'b0;
			if (clr_hw[i])
				next_flags[i] = 1'b0;
			if (ev_rise[i])
				next_flags[i] = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			flags <= '0;
		else
			flags <= next_flags;
	end

	// level sources request only while active
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++)
			pending[i] = src_enable[i] & (src_is_level[i] ? lv_s2[i] : flags[i]);
	end

	cies_prio u_prio (
		.req   (pending),
		.found (found),
		.idx   (win)
	);

	assign take = (state == CIES_RUN) && found && global_enable && !cli_exec
	              && !hold_one && instr_done;

	always_comb begin
		clr_hw = '0;
		if (take && !src_is_level[win])
			clr_hw[win] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// one instruction passes after return or enable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			hold_one <= 1'b0;
		else if (pop_last || sei_exec)
			hold_one <= 1'b1;
		else if (instr_done && state == CIES_RUN)
			hold_one <= 1'b0;
	end

	// global enable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			global_enable <= 1'b0;
		else if (take || cli_exec)
			global_enable <= 1'b0;
		else if (pop_last)
			global_enable <= 1'b1;
		else if (sei_exec)
			global_enable <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state      <= CIES_RUN;
			cnt        <= CNT_ZERO;
			saved_pc   <= RESET_VEC;
			pop_hi     <= 8'h00;
			irq_src    <= '0;
		end else begin
			case (state)
				CIES_RUN: begin
					if (take) begin
						saved_pc <= program_counter;
						irq_src  <= win;
						cnt      <= sleeping ? CNT_WAKE : CNT_RESP;
						state    <= sleeping ? CIES_WAKE : CIES_PUSH;
					end else if (return_from_irq_instr) begin
						cnt   <= CNT_RET;
						state <= CIES_POP;
					end
				end
				CIES_WAKE: begin
					if (startup_done) begin
						if (cnt == CNT_ONE) begin
							cnt   <= CNT_RESP;
							state <= CIES_PUSH;
						end else
							cnt <= cnt - CNT_ONE;
					end
				end
				CIES_PUSH: begin
					if (cnt == CNT_ONE) begin
						cnt   <= CNT_JMP;
						state <= CIES_JUMP;
					end else
						cnt <= cnt - CNT_ONE;
				end
				CIES_JUMP: begin
					if (cnt == CNT_ONE)
						state <= CIES_RUN;
					else
						cnt <= cnt - CNT_ONE;
				end
				CIES_POP: begin
					// read data trails its strobe by a cycle; the high byte sits lower
					if (cnt == CNT_RET - CNT_ONE - CNT_ONE)
						pop_hi <= pop_data;
					if (cnt == CNT_ONE)
						state <= CIES_RUN;
					else
						cnt <= cnt - CNT_ONE;
				end
				default: state <= CIES_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stack and memory strobes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stack_pointer <= SP_RESET;
			mem_write     <= 1'b0;
			mem_read      <= 1'b0;
			mem_addr      <= SP_RESET;
			mem_wdata     <= 8'h00;
		end else begin
			mem_write <= 1'b0;
			mem_read  <= 1'b0;
			if (sp_load)
				stack_pointer <= sp_in;
			// push low then high byte, one decrement each
			else if (state == CIES_PUSH && (cnt == CNT_RESP || cnt == CNT_RESP - CNT_ONE)) begin
				mem_write     <= 1'b1;
				mem_addr      <= stack_pointer;
				mem_wdata     <= (cnt == CNT_RESP) ? saved_pc[7:0] :
				                 8'(saved_pc[PC_W-1:8]);
				stack_pointer <= stack_pointer - SP_STEP;
			end
			// pop high then low, plus two
			else if (state == CIES_POP && (cnt == CNT_RET || cnt == CNT_RET - CNT_ONE)) begin
				mem_read      <= 1'b1;
				mem_addr      <= stack_pointer + SP_STEP;
				stack_pointer <= stack_pointer + SP_STEP;
			end
		end
	end

	// acknowledge and stall
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_ack     <= 1'b0;
			core_stall  <= 1'b0;
			status_save <= 1'b0;
		end else begin
			irq_ack     <= take;
			// status flags never saved by hardware
			status_save <= 1'b0;
			core_stall  <= (state != CIES_RUN) || take || return_from_irq_instr;
		end
	end

	// pc redirect: vector after the push, popped return address after the pop
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pc_load  <= 1'b0;
			pc_value <= RESET_VEC;
		end else begin
			pc_load <= 1'b0;
			if (push_last) begin
				pc_load  <= 1'b1;
				pc_value <= VEC_BASE + PC_W'(irq_src);
			end else if (pop_last) begin
				pc_load  <= 1'b1;
				pc_value <= PC_W'({pop_hi, pop_data});
			end
		end
	end
endmodule : cies_seq

// ---- cies_seq_properties.sv ----
`timescale 1ns/1ns
module cies_seq_properties
	import cies_pkg::*;
(
	// clock and reset
	input wire logic                           mclk,
	input wire logic                           reset_n,
	// pipeline
	input wire logic                           cli_exec,
	input wire logic                           return_from_irq_instr,
	// sequencer outputs
	input wire logic                           global_enable,
	input wire logic                           core_stall,
	input wire logic                           pc_load,
	input wire logic [cies_pkg::PC_W-1:0]      pc_value,
	input wire logic [cies_pkg::SP_W-1:0]      stack_pointer,
	input wire logic                           mem_write,
	input wire logic                           irq_ack,
	input wire logic [cies_pkg::SRC_W-1:0]     irq_src,
	input wire logic                           status_save
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_ack_clears_ge: assert property (irq_ack |-> !global_enable)
		else $error("enable still set at entry");
	a_ack_single: assert property (irq_ack |=> !irq_ack)
		else $error("ack longer than one cycle");
	a_push_writes: assert property (irq_ack |=> mem_write ##1 mem_write)
		else $error("push bytes missing");
	a_stall_entry: assert property (irq_ack |-> core_stall[*4])
		else $error("stall dropped during entry");
	a_vector_load: assert property (irq_ack |-> ##4
		(pc_load && pc_value == PC_W'(irq_src) + VEC_BASE))
		else $error("wrong vector or late");
	a_sp_push: assert property (irq_ack |-> ##4
		stack_pointer == $past(stack_pointer, 4) - 16'h0002)
		else $error("stack pointer not down by two");
	a_sp_pop: assert property (return_from_irq_instr |-> ##5
		stack_pointer == $past(stack_pointer, 5) + 16'h0002)
		else $error("stack pointer not up by two");
	a_cli_blocks: assert property (cli_exec |=> !irq_ack && !global_enable)
		else $error("taken after disable");
	a_return_ge: assert property (return_from_irq_instr |->
		##[1:6] pc_load ##[0:1] global_enable)
		else $error("return did not reload and enable");
	a_no_status: assert property (!status_save)
		else $error("status saved");
endmodule : cies_seq_properties

// ---- cies_stack_mem.sv ----
`timescale 1ns/1ns
module cies_stack_mem (
	// clock
	input  wire logic                      mclk,
	// stack port
	input  wire logic                      mem_write,
	input  wire logic                      mem_read,
	input  wire logic [cies_pkg::SP_W-1:0] mem_addr,
	input  wire logic [7:0]                mem_wdata,
	output logic      [7:0]                pop_data = 8'h5a
);
	logic [7:0] mem [0:511];
	// idle data shows the inverse of the last byte so stale values never pass
	always_ff @(posedge mclk) begin
		if (mem_write)
			mem[mem_addr[8:0]] <= mem_wdata;
		pop_data <= mem_read ? mem[mem_addr[8:0]] : ~pop_data;
	end
endmodule : cies_stack_mem

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	import cies_pkg::*;
	logic               mclk = 0, reset_n = 0, sp_load = 0;
	logic               instr_done = 0, sei_exec = 0, cli_exec = 0, return_from_irq_instr = 0;
	logic [NUM_SRC-1:0] src_event = '0, src_enable = '0, flag_clear_wr = '0, flags;
	logic [NUM_SRC-1:0] src_level = '0, src_is_level = '0;
	logic               global_enable, core_stall, pc_load, mem_write, mem_read, irq_ack, status_save;
	logic [PC_W-1:0]    pc_value;
	logic [SP_W-1:0]    stack_pointer, mem_addr;
	logic [7:0]         mem_wdata, pop_data;
	logic [SRC_W-1:0]   irq_src;
	int                 n_fail = 0, comparisons = 0, cyc = 0;
	cies_seq cies_seq_inst (.mclk, .reset_n, .src_event, .src_level, .src_is_level,
		.src_enable, .flag_clear_wr, .instr_done, .sei_exec, .cli_exec, .return_from_irq_instr,
		.sleeping(1'b0), .startup_done(1'b0), .program_counter(12'h3a5), .sp_in(16'h0100),
		.sp_load, .pop_data, .global_enable, .flags, .core_stall, .pc_load, .pc_value,
		.stack_pointer, .mem_write, .mem_read, .mem_addr, .mem_wdata, .irq_ack, .irq_src,
		.status_save);
	cies_stack_mem cies_stack_mem_inst (.mclk, .mem_write, .mem_read, .mem_addr, .mem_wdata,
		.pop_data);
	initial forever #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// one-cycle pipeline pulse: {return, disable, enable, boundary}
	// ends just after the edge that acts on it, while the one-cycle ack still stands
	task automatic op(logic [3:0] m);
		@(posedge mclk) {return_from_irq_instr, cli_exec, sei_exec, instr_done} <= m;
		@(posedge mclk) {return_from_irq_instr, cli_exec, sei_exec, instr_done} <= 4'h0;
		#1;
	endtask : op
	task automatic settle(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic ret_wait();
		int k;
		k = 0;
		op(4'h8);
		settle(1);
		while (pc_load !== 1'b1 && k < 8) begin
			settle(1);
			k++;
		end
		chk("return pc", pc_value, 16'h03a5);
		settle(1);
		chk("ge after return", global_enable, 1'b1);
		chk("sp after return", stack_pointer, 16'h0100);
	endtask : ret_wait
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 2000) begin
			n_fail++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk) sp_load <= 1'b1;
		@(posedge mclk) sp_load <= 1'b0;
		src_event <= 12'h02a;
		settle(5);
		chk("flags held", flags, 12'h02a);
		@(posedge mclk) flag_clear_wr <= 12'h020;
		@(posedge mclk) flag_clear_wr <= 12'h000;
		settle(1);
		chk("flags cleared", flags, 12'h00a);
		op(4'h1);
		chk("no take disabled", irq_ack, 1'b0);
		@(posedge mclk) src_enable <= 12'hfff;
		op(4'h2);
		op(4'h1);
		chk("hold after enable", irq_ack, 1'b0);
		op(4'h1);
		chk("ack", irq_ack, 1'b1);
		chk("src", irq_src, 4'h1);
		chk("ge entry", global_enable, 1'b0);
		chk("flag hw clear", flags, 12'h008);
		settle(1);
		chk("push write", mem_write, 1'b1);
		chk("push addr", mem_addr, 16'h0100);
		chk("push low byte", mem_wdata, 8'ha5);
		settle(1);
		chk("push high addr", mem_addr, 16'h00ff);
		chk("push high byte", mem_wdata, 8'h03);
		settle(2);
		chk("vector load", pc_load, 1'b1);
		chk("vector", pc_value, 16'h0002);
		settle(3);
		chk("sp after push", stack_pointer, 16'h00fe);
		ret_wait();
		op(4'h1);
		chk("one instr after return", irq_ack, 1'b0);
		op(4'h1);
		chk("next ack", irq_ack, 1'b1);
		chk("next src", irq_src, 4'h3);
		@(posedge mclk) src_event <= 12'h000;
		settle(3);
		@(posedge mclk) src_event <= 12'h002;
		settle(5);
		chk("pending under disable", flags, 12'h002);
		ret_wait();
		op(4'h1);
		op(4'h5);
		chk("disable same cycle", irq_ack, 1'b0);
		chk("ge after disable", global_enable, 1'b0);
		chk("status save", status_save, 1'b0);
		// a level source that drops before enabling is not served until it rises again
		@(posedge mclk) begin
			flag_clear_wr <= 12'h002;
			src_is_level  <= 12'h020;
			src_level     <= 12'h020;
		end
		@(posedge mclk) flag_clear_wr <= 12'h000;
		settle(3);
		chk("level has no flag", flags, 12'h000);
		@(posedge mclk) src_level <= 12'h000;
		settle(3);
		op(4'h2);
		op(4'h1);
		op(4'h1);
		chk("vanished level", irq_ack, 1'b0);
		@(posedge mclk) src_level <= 12'h020;
		settle(3);
		op(4'h1);
		chk("level taken", irq_ack, 1'b1);
		chk("level src", irq_src, 4'h5);
		@(posedge mclk) src_level <= 12'h000;
		settle(6);
		chk("level vector", pc_value, 16'h0006);
		ret_wait();
		close_out();
	end
endmodule : tb
bind cies_seq cies_seq_properties cies_seq_properties_inst (.mclk, .reset_n, .cli_exec,
	.return_from_irq_instr, .global_enable, .core_stall, .pc_load, .pc_value, .stack_pointer,
	.mem_write, .irq_ack, .irq_src, .status_save);
